// ===== hw/sclk_ctrl.sv
// Functional notes
// - system clock from ring, pin or loop
// - ring oscillator selected after reset
// - loop reference is the crystal output
// - loop path always through pre-scaler
// - twelve-bit feedback divider to loop
// - pre-scaler divides by 1..32 one-hot
// - sticky not-locked flag on lock loss
// - sticky locked flag on lock
// - flags held until software clears each
// - pin source bypasses loop entirely
// - source switch through glitch-free mux
// - loop, crystal, fabric buffers gateable
// - alternate fabric clock crystal or pre-scaler
// - control bits 0 and 1 pick sources
// - divider 19:8, one-hot pre-scaler 28:24
// - control bits 5..2 enables and alt select
// - status 1 locked, 0 not-locked, w1c at clear register
`timescale 1ns/100ps
module sclk_ctrl #(
  parameter int unsigned NUM_GBUF = sclk_pkg::NUM_GBUF
) (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [sclk_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      ring_osc_in,
  input  wire logic                      ext_clk_in,
  input  wire logic                      xtal_in,
  input  wire logic                      pll_vco_in,
  input  wire logic                      pll_lock_in,
  output logic                           sys_clk_out,
  output logic                           alt_clock_out,
  output logic                           pll_feedback_out,
  output logic                           pll_enable,
  output logic                           crystal_osc_enable,
  output logic [sclk_pkg::DIV_W-1:0]     pll_div_count,
  output logic [NUM_GBUF-1:0]            fabric_global_buffers,
  output logic [1:0]                     active_source,
  output logic                           switch_busy
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [31:0]                   ctrl;
    logic                          lock;
    logic                          nlock;
    logic [sclk_pkg::NUM_SYNC-1:0] sync1;
    logic [sclk_pkg::NUM_SYNC-1:0] sync2;
    logic                          vco_prev;
    logic [sclk_pkg::SCALE_W-1:0]  pre_cnt;
    logic                          pre_out;
    logic [sclk_pkg::DIV_W-1:0]    fb_cnt;
    logic                          fb_out;
    logic                          alt_out;
    logic [31:0]                   rdata;
  } sclk_state_t;

  sclk_state_t st_reg;
  sclk_state_t st_next;

  sclk_mux_if mif ();

  // ****************************************
  // helpers
  // ****************************************
  // 0 means undivided, k+1 means bit k of counter
  function automatic logic [2:0] scale_idx(input logic [sclk_pkg::SCALE_W-1:0] f);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = 0; i < int'(sclk_pkg::SCALE_W); i++) begin
      if (f[i]) begin
        idx = 3'(i + 1);
      end
    end
    return idx;
  endfunction : scale_idx

  function automatic logic is_mapped(input logic [sclk_pkg::ADDR_W-1:0] a);
    if (a == sclk_pkg::OFF_CTRL) begin
      return 1'b1;
    end else if (a == sclk_pkg::OFF_STAT) begin
      return 1'b1;
    end else if (a == sclk_pkg::OFF_CLR) begin
      return 1'b1;
    end else begin
      return 1'b0;
    end
  endfunction : is_mapped

  // ****************************************
  // combinational signals
  // ****************************************
  logic                         setup_ph;
  logic                         access_ph;
  logic                         wr_ok;
  logic                         vco_rise;
  logic                         pll_on;
  logic                         lock_s;
  logic [2:0]                   sidx;
  logic [sclk_pkg::DIV_W-1:0]   div;
  logic [sclk_pkg::SCALE_W-1:0] pre_cnt_n;

  // ****************************************
  // next state
  // ****************************************

  always_comb begin
    st_next   = st_reg;
    setup_ph  = psel && !penable;
    access_ph = psel && penable;
    wr_ok     = access_ph && pwrite && is_mapped(paddr);
    pll_on    = st_reg.ctrl[sclk_pkg::CTRL_PLL_EN];
    div       = st_reg.ctrl[sclk_pkg::DIV_LSB +: sclk_pkg::DIV_W];
    sidx      = scale_idx(st_reg.ctrl[sclk_pkg::SCALE_LSB +: sclk_pkg::SCALE_W]);
    pre_cnt_n = st_reg.pre_cnt;

    // ****************************************
    // input synchronisers
    // ****************************************
    // two-flop synchronisers on all pins
    st_next.sync1 = {pll_lock_in, pll_vco_in, xtal_in, ext_clk_in, ring_osc_in};
    st_next.sync2 = st_reg.sync1;
    lock_s        = st_reg.sync2[sclk_pkg::SY_LOCK];
    vco_rise      = st_reg.sync2[sclk_pkg::SY_VCO] && !st_reg.vco_prev;
    st_next.vco_prev = st_reg.sync2[sclk_pkg::SY_VCO];

    // ****************************************
    // control register
    // ****************************************
    // control register write, reserved bits kept zero
    if (wr_ok && paddr == sclk_pkg::OFF_CTRL) begin
      st_next.ctrl = pwdata & sclk_pkg::CTRL_MASK;
    end

    // ****************************************
    // lock flags
    // ****************************************
    // one clears the flag
    if (wr_ok && paddr == sclk_pkg::OFF_CLR) begin
      if (pwdata[sclk_pkg::STAT_LOCK]) begin
        st_next.lock = 1'b0;
      end
      if (pwdata[sclk_pkg::STAT_NLOCK]) begin
        st_next.nlock = 1'b0;
      end
    end
    if (lock_s) begin
      st_next.lock = 1'b1;
    end
    if (!lock_s) begin
      st_next.nlock = 1'b1;
    end

    // ****************************************
    // loop dividers
    // ****************************************
    // loop disabled stops dividers
    if (!pll_on) begin
      st_next.pre_cnt = '0;
      st_next.fb_cnt  = '0;
      st_next.pre_out = 1'b0;
      st_next.fb_out  = 1'b0;
    end else begin
      if (vco_rise) begin
        pre_cnt_n = st_reg.pre_cnt + 5'h01;
      end
      st_next.pre_cnt = pre_cnt_n;
      if (sidx == 3'h0) begin
        st_next.pre_out = st_reg.sync2[sclk_pkg::SY_VCO];
      end else begin
        st_next.pre_out = pre_cnt_n[sidx - 3'h1];
      end
      if (div == '0) begin
        st_next.fb_cnt = '0;
      end else if (vco_rise) begin
        if (st_reg.fb_cnt >= div - 12'h001) begin
          st_next.fb_cnt = '0;
        end else begin
          st_next.fb_cnt = st_reg.fb_cnt + 12'h001;
        end
      end
      st_next.fb_out = (div != '0) && (st_next.fb_cnt < (div >> 1));
    end

    // ****************************************
    // alternate fabric clock
    // ****************************************
    // alternate fabric clock select
    if (st_reg.ctrl[sclk_pkg::CTRL_ALT_SEL]) begin
      st_next.alt_out = st_reg.pre_out;
    end else begin
      st_next.alt_out = st_reg.ctrl[sclk_pkg::CTRL_XTAL_EN] && st_reg.sync2[sclk_pkg::SY_XTAL];
    end

    // ****************************************
    // read data
    // ****************************************
    // read data captured in setup phase
    if (setup_ph && !pwrite) begin
      if (paddr == sclk_pkg::OFF_CTRL) begin
        st_next.rdata = st_reg.ctrl;
      end else if (paddr == sclk_pkg::OFF_STAT) begin
        st_next.rdata = '0;
        st_next.rdata[sclk_pkg::STAT_LOCK]  = st_reg.lock;
        st_next.rdata[sclk_pkg::STAT_NLOCK] = st_reg.nlock;
      end else begin
        st_next.rdata = '0;
      end
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg       <= '0;
      st_reg.ctrl  <= sclk_pkg::CTRL_RST;
      st_reg.lock  <= sclk_pkg::LOCK_RST;
      st_reg.nlock <= sclk_pkg::NLOCK_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // clock source selection
  // ****************************************
  // three-way source choice
  assign mif.src_req  = !st_reg.ctrl[sclk_pkg::CTRL_CLK_SEL] ? sclk_pkg::SCLK_SRC_RING :
                        st_reg.ctrl[sclk_pkg::CTRL_PLL_SEL] ? sclk_pkg::SCLK_SRC_PRE :
                        sclk_pkg::SCLK_SRC_EXT;
  assign mif.ring_lvl = st_reg.sync2[sclk_pkg::SY_RING];
  assign mif.ext_lvl  = st_reg.sync2[sclk_pkg::SY_EXT];
  assign mif.pre_lvl  = st_reg.pre_out;

  sclk_glitchfree_mux u_mux (
    .pclk    (pclk),
    .presetn (presetn),
    .mif     (mif)
  );

  // ****************************************
  // bus outputs
  // ****************************************
  assign prdata             = st_reg.rdata;
  assign pready             = psel && penable;
  assign pslverr            = psel && penable && !is_mapped(paddr);

  // ****************************************
  // clock and enable outputs
  // ****************************************
  assign sys_clk_out        = mif.sys_clk;
  assign active_source      = mif.cur_src;
  assign switch_busy        = mif.busy;
  assign alt_clock_out      = st_reg.alt_out;
  assign crystal_osc_enable = st_reg.ctrl[sclk_pkg::CTRL_XTAL_EN];
  assign pll_enable         = st_reg.ctrl[sclk_pkg::CTRL_PLL_EN];
  assign pll_div_count      = st_reg.ctrl[sclk_pkg::DIV_LSB +: sclk_pkg::DIV_W];
  assign pll_feedback_out   = st_reg.fb_out;

  // ****************************************
  // fabric buffers
  // ****************************************
  // fabric buffer gating
  generate
    for (genvar g = 0; g < int'(NUM_GBUF); g++) begin : g_gbuf
      assign fabric_global_buffers[g] = st_reg.ctrl[sclk_pkg::CTRL_GBUF_EN];
    end
  endgenerate

endmodule : sclk_ctrl

// ===== hw/sclk_pkg.sv
package sclk_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam int unsigned ADDR_W     = 12;
  localparam logic [11:0] OFF_CTRL   = 12'h000;
  localparam logic [11:0] OFF_STAT   = 12'h004;
  localparam logic [11:0] OFF_CLR    = 12'h008;

  // ****************************************
  // clock_control fields
  // ****************************************
  localparam int unsigned CTRL_CLK_SEL  = 0;
  localparam int unsigned CTRL_PLL_SEL  = 1;
  localparam int unsigned CTRL_ALT_SEL  = 2;
  localparam int unsigned CTRL_GBUF_EN  = 3;
  localparam int unsigned CTRL_XTAL_EN  = 4;
  localparam int unsigned CTRL_PLL_EN   = 5;
  localparam int unsigned DIV_LSB       = 8;
  localparam int unsigned DIV_W         = 12;
  localparam int unsigned SCALE_LSB     = 24;
  localparam int unsigned SCALE_W       = 5;
  localparam logic [31:0] CTRL_MASK     = 32'h1F0FFF3F;
  localparam logic [31:0] CTRL_RST      = 32'h00040000;

  // ****************************************
  // status and clear fields
  // ****************************************
  localparam int unsigned STAT_NLOCK    = 0;
  localparam int unsigned STAT_LOCK     = 1;
  localparam logic        NLOCK_RST     = 1'b1;
  localparam logic        LOCK_RST      = 1'b0;

  // ****************************************
  // fabric and synchroniser layout
  // ****************************************
  localparam int unsigned NUM_GBUF      = 6;
  localparam int unsigned NUM_SYNC      = 5;
  localparam int unsigned SY_RING       = 0;
  localparam int unsigned SY_EXT        = 1;
  localparam int unsigned SY_XTAL       = 2;
  localparam int unsigned SY_VCO        = 3;
  localparam int unsigned SY_LOCK       = 4;

  // ****************************************
  // clock sources
  // ****************************************
  typedef enum logic [1:0] {
    SCLK_SRC_RING,
    SCLK_SRC_EXT,
    SCLK_SRC_PRE
  } sclk_src_t;

endpackage : sclk_pkg

// ===== hw/sclk_mux_if.sv
`timescale 1ns/100ps
interface sclk_mux_if;
  sclk_pkg::sclk_src_t src_req;
  logic                ring_lvl;
  logic                ext_lvl;
  logic                pre_lvl;
  logic                sys_clk;
  sclk_pkg::sclk_src_t cur_src;
  logic                busy;

  modport ctrl (
    output src_req, ring_lvl, ext_lvl, pre_lvl,
    input  sys_clk, cur_src, busy
  );

  modport mux (
    input  src_req, ring_lvl, ext_lvl, pre_lvl,
    output sys_clk, cur_src, busy
  );
endinterface : sclk_mux_if

// ===== hw/sclk_glitchfree_mux.sv
`timescale 1ns/100ps
module sclk_glitchfree_mux (
  input wire logic pclk,
  input wire logic presetn,
  sclk_mux_if.mux  mif
);

  // ****************************************
  // state
  // ****************************************
  typedef enum logic {
    SCLK_MUX_RUN,
    SCLK_MUX_STOP
  } sclk_mux_st_t;

  typedef struct packed {
    sclk_mux_st_t        st;
    sclk_pkg::sclk_src_t cur;
    logic                out;
  } sclk_mux_t;

  sclk_mux_t mux_reg;
  sclk_mux_t mux_next;

  function automatic logic src_lvl(input sclk_pkg::sclk_src_t s, input logic r, input logic e,
                                   input logic p);
    if (s == sclk_pkg::SCLK_SRC_RING) begin
      return r;
    end else if (s == sclk_pkg::SCLK_SRC_EXT) begin
      return e;
    end else begin
      return p;
    end
  endfunction : src_lvl

  // ****************************************
  // switch sequencing
  // ****************************************
  always_comb begin
    mux_next = mux_reg;
    case (mux_reg.st)
      SCLK_MUX_RUN: begin
        if (mux_next.cur != mif.src_req &&
            !src_lvl(mux_reg.cur, mif.ring_lvl, mif.ext_lvl, mif.pre_lvl)) begin
          mux_next.st = SCLK_MUX_STOP;
        end
      end
      default: begin
        if (!src_lvl(mif.src_req, mif.ring_lvl, mif.ext_lvl, mif.pre_lvl)) begin
          mux_next.cur = mif.src_req;
          mux_next.st  = SCLK_MUX_RUN;
        end
      end
    endcase
    mux_next.out = (mux_next.st == SCLK_MUX_RUN) &&
                   src_lvl(mux_next.cur, mif.ring_lvl, mif.ext_lvl, mif.pre_lvl);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mux_reg <= '{st: SCLK_MUX_RUN, cur: sclk_pkg::SCLK_SRC_RING, out: 1'b0};
    end else begin
      mux_reg <= mux_next;
    end
  end

  assign mif.sys_clk = mux_reg.out;
  assign mif.cur_src = mux_reg.cur;
  assign mif.busy    = (mux_reg.st != SCLK_MUX_RUN) || (mux_reg.cur != mif.src_req);

endmodule : sclk_glitchfree_mux

// ===== verif/sclk_ctrl_asserts.sv
`timescale 1ns/100ps
module sclk_ctrl_asserts #(
  parameter int unsigned NUM_GBUF = 6
) (
  input wire logic                          pclk,
  input wire logic                          presetn,
  input wire logic                          psel,
  input wire logic                          penable,
  input wire logic                          pwrite,
  input wire logic [sclk_pkg::ADDR_W-1:0]   paddr,
  input wire logic [31:0]                   pwdata,
  input wire logic [31:0]                   prdata,
  input wire logic                          pready,
  input wire logic                          pslverr,
  input wire logic                          pll_lock_in,
  input wire logic                          sys_clk_out,
  input wire logic                          pll_feedback_out,
  input wire logic                          pll_enable,
  input wire logic                          crystal_osc_enable,
  input wire logic [sclk_pkg::DIV_W-1:0]    pll_div_count,
  input wire logic [NUM_GBUF-1:0]           fabric_global_buffers,
  input wire logic [1:0]                    active_source,
  input wire logic                          switch_busy
);
  // ********
  // source shadow
  // ********
  logic [1:0] sh_sel_reg;
  logic [2:0] quiet_reg;
  logic [1:0] want_src;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_sel_reg <= 2'h0;
      quiet_reg  <= 3'h0;
    end else if (psel && penable && pwrite && paddr == sclk_pkg::OFF_CTRL) begin
      sh_sel_reg <= pwdata[1:0];
      quiet_reg  <= 3'h0;
    end else if (quiet_reg != 3'h7) begin
      quiet_reg <= quiet_reg + 3'h1;
    end
  end
  assign want_src = !sh_sel_reg[0] ? 2'h0 : (sh_sel_reg[1] ? 2'h2 : 2'h1);

  // ********
  // properties
  // ********
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_wr_ctrl;
    psel && penable && pwrite && paddr == sclk_pkg::OFF_CTRL;
  endsequence
  sequence s_rd_setup;
    psel && !penable && !pwrite;
  endsequence

  AST_BUS_ERR: assert property (psel && penable |-> pready && (pslverr == (paddr != sclk_pkg::OFF_CTRL &&
    paddr != sclk_pkg::OFF_STAT && paddr != sclk_pkg::OFF_CLR))) else $error("bus answer wrong");
  AST_DIV: assert property (s_wr_ctrl |=> pll_div_count == $past(pwdata[19:8])) else $error("divider wrong");
  AST_EN: assert property (s_wr_ctrl |=> pll_enable == $past(pwdata[5]) &&
    crystal_osc_enable == $past(pwdata[4])) else $error("enable wrong");
  AST_GBUF: assert property (s_wr_ctrl |=> fabric_global_buffers == {NUM_GBUF{$past(pwdata[3])}})
    else $error("buffers wrong");
  AST_LOCKED: assert property (s_rd_setup ##0 (paddr == sclk_pkg::OFF_STAT && $past(pll_lock_in, 3) &&
    $past(pll_lock_in, 4) && $past(presetn, 4)) |=> prdata[1]) else $error("locked flag missing");
  AST_NLOCK: assert property (s_rd_setup ##0 (paddr == sclk_pkg::OFF_STAT && !$past(pll_lock_in, 3) &&
    !$past(pll_lock_in, 4)) |=> prdata[0]) else $error("not-locked flag missing");
  AST_CLR_RD: assert property (s_rd_setup ##0 paddr == sclk_pkg::OFF_CLR |=> prdata == 32'h0)
    else $error("clear register read not zero");
  AST_SRC: assert property (quiet_reg == 3'h7 && !switch_busy |-> active_source == want_src)
    else $error("source wrong");
  AST_HI_RUNT: assert property ($rose(sys_clk_out) |=> sys_clk_out) else $error("runt high pulse");
  AST_LO_RUNT: assert property ($fell(sys_clk_out) |=> !sys_clk_out) else $error("runt low pulse");
  AST_FB_OFF: assert property (!pll_enable [*3] |-> !pll_feedback_out) else $error("feedback runs");
  AST_RST_RING: assert property ($rose(presetn) |-> active_source == 2'h0 && !sys_clk_out)
    else $error("not on ring after reset");
endmodule : sclk_ctrl_asserts

bind sclk_ctrl sclk_ctrl_asserts #(.NUM_GBUF(NUM_GBUF)) u_sclk_ctrl_asserts (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pll_lock_in(pll_lock_in),
  .sys_clk_out(sys_clk_out), .pll_feedback_out(pll_feedback_out), .pll_enable(pll_enable),
  .crystal_osc_enable(crystal_osc_enable), .pll_div_count(pll_div_count),
  .fabric_global_buffers(fabric_global_buffers), .active_source(active_source), .switch_busy(switch_busy));

// ===== verif/sclk_ctrl_bench.sv
`timescale 1ns/100ps
module sclk_ctrl_bench;
  logic                          pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0]                   paddr = 12'h000;
  logic [31:0]                   pwdata = 32'h0, prdata, rd, ctrl_m = 32'h00040000, v, base;
  logic                          pready, pslverr, er, sys_clk_out, alt_clock_out, pll_feedback_out;
  logic                          ring_osc_in = 1'b0, ext_clk_in = 1'b0, xtal_in = 1'b0, pll_vco_in = 1'b0;
  logic                          pll_lock_in = 1'b0, pll_enable, crystal_osc_enable, switch_busy;
  logic [sclk_pkg::DIV_W-1:0]    pll_div_count;
  logic [sclk_pkg::NUM_GBUF-1:0] fabric_global_buffers;
  logic [1:0]                    active_source, stat_m = 2'b01;
  int                            err_count = 0, checked = 0, cnt = 0, p;

  sclk_ctrl u_sclk_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ring_osc_in(ring_osc_in), .ext_clk_in(ext_clk_in), .xtal_in(xtal_in), .pll_vco_in(pll_vco_in),
    .pll_lock_in(pll_lock_in), .sys_clk_out(sys_clk_out), .alt_clock_out(alt_clock_out),
    .pll_feedback_out(pll_feedback_out), .pll_enable(pll_enable), .crystal_osc_enable(crystal_osc_enable),
    .pll_div_count(pll_div_count), .fabric_global_buffers(fabric_global_buffers),
    .active_source(active_source), .switch_busy(switch_busy));

  // ********
  // clocks and sources
  // ********
  always #2.5 pclk = ~pclk;
  always_ff @(posedge pclk) begin
    cnt         <= cnt + 1;
    ring_osc_in <= (cnt % 10) < 5;
    ext_clk_in  <= (cnt % 6) < 3;
    xtal_in     <= (cnt % 14) < 7;
    pll_vco_in  <= (cnt % 4) < 2;
  end

  // ********
  // tasks
  // ********
  task automatic end_sim();
    $display("checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
    if (a == sclk_pkg::OFF_CTRL) ctrl_m = d & sclk_pkg::CTRL_MASK;
    if (a == sclk_pkg::OFF_CLR) stat_m = stat_m & ~d[1:0];
  endtask : wr
  task automatic rchk(input logic [11:0] a, input logic [31:0] e, input string nm);
    apb(a, 1'b0, 32'h0);
    cmp(nm, e, rd);
    cmp("pslverr", 32'h0, 32'(er));
  endtask : rchk
  function automatic logic [31:0] st();
    stat_m = stat_m | (pll_lock_in ? 2'b10 : 2'b01);
    return {30'h0, stat_m};
  endfunction : st
  function automatic logic sig(input int s);
    return (s == 0) ? sys_clk_out : ((s == 1) ? alt_clock_out : pll_feedback_out);
  endfunction : sig
  task automatic rise(input int s);
    logic q;
    q = sig(s);
    for (int i = 0; i < 20000; i++) begin
      @(posedge pclk);
      if (q === 1'b0 && sig(s) === 1'b1) break;
      q = sig(s);
    end
  endtask : rise
  task automatic per(input int s, input int e, input string nm);
    int t0;
    rise(s);
    rise(s);
    t0 = cnt;
    rise(s);
    cmp(nm, e, cnt - t0);
  endtask : per
  task automatic sel(input logic [31:0] d, input logic [1:0] src);
    wr(sclk_pkg::OFF_CTRL, ctrl_m & ~32'h1);
    wr(sclk_pkg::OFF_CTRL, d & ~32'h1);
    if (src == 2'h2) begin
      wr(sclk_pkg::OFF_CLR, 32'h2);
      rd = 32'h0;
      while (rd[1] !== 1'b1) begin
        apb(sclk_pkg::OFF_STAT, 1'b0, 32'h0);
      end
    end
    wr(sclk_pkg::OFF_CTRL, d);
    for (int i = 0; i < 600 && (switch_busy !== 1'b0 || active_source !== src); i++) @(posedge pclk);
    cmp("active_source", 32'(src), 32'(active_source));
    cmp("switch_busy", 32'h0, 32'(switch_busy));
  endtask : sel

  initial begin
    repeat (60000) @(posedge pclk);
    err_count++;
    $display("[ERR] watchdog expected done seen timeout");
    end_sim();
  end
  initial begin
    void'($urandom(32'h7b68176a));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rchk(sclk_pkg::OFF_CTRL, 32'h00040000, "ctrl");
    rchk(sclk_pkg::OFF_STAT, st(), "stat");
    rchk(sclk_pkg::OFF_CLR, 32'h0, "clear");
    cmp("active_source", 32'h0, 32'(active_source));
    $display("test reset done");
    repeat (8) begin
      v = ($urandom() & 32'hFFF000FE) | ((32'd1000 + $urandom_range(2000)) << 8);
      wr(sclk_pkg::OFF_CTRL, v);
      rchk(sclk_pkg::OFF_CTRL, ctrl_m, "ctrl");
      cmp("div", 32'(ctrl_m[19:8]), 32'(pll_div_count));
      cmp("enables", {24'h0, ctrl_m[5:4], {sclk_pkg::NUM_GBUF{ctrl_m[3]}}},
        {24'h0, pll_enable, crystal_osc_enable, fabric_global_buffers});
    end
    $display("test control done");
    wr(12'h00C, 32'hFFFFFFFF);
    cmp("pslverr", 32'h1, 32'(er));
    apb(12'h010, 1'b0, 32'h0);
    cmp("unmapped", 32'h1, {rd[30:0], er});
    wr(sclk_pkg::OFF_STAT, 32'hFFFFFFFF);
    rchk(sclk_pkg::OFF_CTRL, ctrl_m, "ctrl");
    $display("test refusal done");
    pll_lock_in <= 1'b1;
    repeat (6) @(posedge pclk);
    rchk(sclk_pkg::OFF_STAT, st(), "stat");
    wr(sclk_pkg::OFF_CLR, 32'h1);
    rchk(sclk_pkg::OFF_STAT, st(), "stat");
    wr(sclk_pkg::OFF_CLR, 32'h2);
    rchk(sclk_pkg::OFF_STAT, st(), "stat");
    pll_lock_in <= 1'b0;
    repeat (6) @(posedge pclk);
    rchk(sclk_pkg::OFF_STAT, st(), "stat");
    wr(sclk_pkg::OFF_CLR, 32'h2);
    rchk(sclk_pkg::OFF_STAT, st(), "stat");
    wr(sclk_pkg::OFF_CLR, 32'h0);
    rchk(sclk_pkg::OFF_STAT, st(), "stat");
    pll_lock_in <= 1'b1;
    $display("test flags done");
    base = (32'd1000 << 8) | 32'h30;
    sel(base | 32'h1, 2'h1);
    per(0, 6, "pin period");
    sel(base, 2'h0);
    per(0, 10, "ring period");
    for (int k = 0; k < 6; k++) begin
      sel(base | 32'h7 | (((k == 0) ? 32'h0 : (32'h1 << (k - 1))) << 24), 2'h2);
      per(0, 4 << k, "loop period");
      per(1, 4 << k, "alt period");
    end
    wr(sclk_pkg::OFF_CTRL, ctrl_m & ~32'h4);
    per(1, 14, "alt crystal period");
    per(2, 4000, "feedback period");
    $display("test sources done");
    end_sim();
  end
endmodule : sclk_ctrl_bench
